// ==== include/bridge_consts.svh ====
// Constants for the host-to-target serial bridge
`ifndef BRIDGE_CONSTS_SVH
`define BRIDGE_CONSTS_SVH
`define CLK_HZ       125000000
`define CLK_PER_NS   8
`define CYC_PER_MS   (`CLK_HZ / 1000)
`define BAUD_MIN     1200
`define BAUD_MAX     500000
`define BAUD_OVR     9600
`define LEGACY_MAX   50
`define PAYLOAD_MIN  498
`define FRAME_BYTES  64
`define TX_FRAMES    4
`define RX_FRAMES    8
`define FLUSH_MS     100
`define SOF_MS       1
`define FLUSH_SOFS   (`FLUSH_MS / `SOF_MS)
`define BRK_BITS     11
`define BRK_MS_MAX   65534
`define BRK_CAP_CYC  ((`BRK_BITS * `CLK_HZ) / `BAUD_MIN)
`define PREFIX_LEN   14
`define PREFIX_TEXT  "CMD:SEND_UART="
`define DIV_W        17
`endif

// ==== include/bridge_pkg.sv ====
// Types shared by the serial bridge modules
package bridge_pkg;
    typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} parity_e;
    typedef enum logic [2:0] {OV_IDLE, OV_PREFIX, OV_SEND, OV_DISCARD, OV_DRAIN} ovr_state_e;
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_BREAK} tx_state_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_e;
    typedef logic [16:0] div_t;
endpackage

// ==== include/frame_fifo_if.sv ====
// Carrier between the bridge core and its frame queues
`timescale 1ns/1ns
interface frame_fifo_if #(parameter int W = 9);
    logic [W-1:0] wr_data;
    logic         wr_valid;
    logic         wr_ready;
    logic         commit;
    logic         rewind;
    logic [W-1:0] rd_data;
    logic         rd_valid;
    logic         rd_ready;
    modport store(input wr_data, wr_valid, commit, rewind, rd_ready,
                  output wr_ready, rd_data, rd_valid);
    modport user(output wr_data, wr_valid, commit, rewind, rd_ready,
                 input wr_ready, rd_data, rd_valid);
endinterface

// ==== rtl/frame_fifo.sv ====
// Frame queue: reads stop at the last committed word, rewind drops the rest
`timescale 1ns/1ns
module frame_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 32
) (
    input wire logic    sys_clk,
    input wire logic    rst,
    frame_fifo_if.store q
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp;
    logic [AW:0]  rp;
    logic [AW:0]  mark;
    logic         wr_fire;
    logic         rd_fire;

    // Uncommitted words still occupy space, so full is honest
    assign q.wr_ready = (wp - rp) != (AW + 1)'(DEPTH);
    assign q.rd_valid = rp != mark;
    assign q.rd_data  = mem[rp[AW-1:0]];
    assign wr_fire    = q.wr_valid && q.wr_ready && !q.rewind;
    assign rd_fire    = q.rd_valid && q.rd_ready;

    always_ff @(posedge sys_clk) begin
        if (wr_fire) begin
            mem[wp[AW-1:0]] <= q.wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wp   <= '0;
            rp   <= '0;
            mark <= '0;
        end else begin
            if (rd_fire) begin
                rp <= rp + 1'b1;
            end
            if (q.rewind) begin
                wp <= mark;
            end else if (wr_fire) begin
                wp <= wp + 1'b1;
            end
            if (q.commit && !q.rewind) begin
                mark <= wp + (AW + 1)'(wr_fire);
            end
        end
    end
endmodule

// ==== rtl/usb_uart_bridge.sv ====
// Serial bridge core: frame queues, UART engines, override sender, break
`timescale 1ns/1ns
`include "bridge_consts.svh"
// What this block does
// (RQ1) A file starting with the send prefix is transmitted on the bridge line.
// (RQ2) Legacy override sends at most 50 characters and drops the rest.
// (RQ3) Legacy override uses 9600 bps unless a session already set a rate.
// (RQ4) Newer override streams any length, so a 498-character payload fits.
// (RQ5) Newer override stops at the first null character.
// (RQ6) Newer override always transmits at 9600 bps.
// (RQ7) An active session is paused during override and resumed after.
// (RQ8) Host should not mix override with session traffic.
// (RQ9) Host data arrive as frames of up to 64 bytes, queued whole.
// (RQ10) At most four outbound frames held; further host frames are throttled.
// (RQ11) Received bytes are packed into 64-byte frames for the host.
// (RQ12) Partial receive frames are flushed every 100 start-of-frame ticks.
// (RQ13) Up to eight receive frames may be in flight.
// (RQ14) On receive overrun the last filled frame is recycled and lost.
// (RQ15) Host should drain receive data steadily or target slow down.
// (RQ16) A break holds the transmit line low for at least 11 bit times.
// (RQ17) A break aborts the character being sent.
// (RQ18) Host must not request a break during override.
// (RQ19) Host should let the transmit queue empty before a break.
// (RQ20) Timed breaks are capped at 11 bits at the lowest baud rate.
// (RQ21) Host-timed breaks last until the host releases them.
// (RQ22) Baud rate clamped to 1200 bps..500 kbps, changeable at any time.
// (RQ23) Eight data bits, odd/even/no parity, one or two stop bits.
// (RQ24) New data enter the queues only while the host asserts terminal ready.
// (RQ25) Frames and bytes leave in order with standard async framing.
module usb_uart_bridge
    import bridge_pkg::*;
#(
    parameter int          TX_DEPTH    = 32,
    parameter int          RX_DEPTH    = `RX_FRAMES * `FRAME_BYTES,
    parameter logic [33:0] BRK_CAP_CYC = 34'(`BRK_CAP_CYC)
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        dtr,
    input  wire logic        variant_new,
    input  wire logic        line_cfg_valid,
    input  wire logic [31:0] baud_req,
    input  wire parity_e     parity,
    input  wire logic        two_stop,
    input  wire logic [7:0]  h2t_data,
    input  wire logic        h2t_valid,
    input  wire logic        h2t_last,
    output logic             h2t_ready,
    output logic [7:0]       t2h_data,
    output logic             t2h_valid,
    output logic             t2h_last,
    input  wire logic        t2h_ready,
    input  wire logic        sof,
    input  wire logic [7:0]  ovr_data,
    input  wire logic        ovr_valid,
    input  wire logic        ovr_first,
    input  wire logic        ovr_last,
    output logic             ovr_ready,
    output logic             ovr_active,
    input  wire logic        brk_hold,
    input  wire logic        brk_timed,
    input  wire logic [15:0] brk_ms,
    output logic             brk_active,
    input  wire logic        bridge_rx_line,
    output logic             bridge_tx_line
);
    localparam logic [8*`PREFIX_LEN-1:0] PREFIX = `PREFIX_TEXT;

    function automatic div_t baud_div(input logic [31:0] rate);
        logic [31:0] r;
        r = (rate < `BAUD_MIN) ? `BAUD_MIN : ((rate > `BAUD_MAX) ? `BAUD_MAX : rate);
        return div_t'(`CLK_HZ / r);
    endfunction

    function automatic logic [7:0] prefix_char(input logic [3:0] i);
        return PREFIX[8*(`PREFIX_LEN - 1 - int'(i)) +: 8];
    endfunction

    frame_fifo_if #(.W(9)) txq ();
    frame_fifo_if #(.W(9)) rxq ();

    frame_fifo #(.W(9), .DEPTH(TX_DEPTH)) u_txq (.sys_clk(sys_clk), .rst(rst), .q(txq.store));
    frame_fifo #(.W(9), .DEPTH(RX_DEPTH)) u_rxq (.sys_clk(sys_clk), .rst(rst), .q(rxq.store));

    // ************************************************************
    // Line rate
    // ************************************************************
    localparam div_t DIV_OVR = baud_div(`BAUD_OVR);
    div_t sess_div;
    div_t cur_div;
    logic ovr_keep;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sess_div <= DIV_OVR;
        end else begin
            sess_div <= baud_div(baud_req); // RQ22
        end
    end

    assign ovr_keep = !variant_new && (line_cfg_valid || dtr); // RQ3

    // ************************************************************
    // Override sender
    // ************************************************************
    ovr_state_e ov;
    logic [3:0] pfx_idx;
    logic [5:0] ov_cnt;
    logic       ov_fire;
    logic       tx_free;
    logic       take_ovr;
    logic       take_fifo;
    logic       brk_go;
    tx_state_e  tx_st;

    assign ovr_active = (ov == OV_SEND) || (ov == OV_DISCARD) || (ov == OV_DRAIN);
    assign ovr_ready  = (ov == OV_DRAIN) ? 1'b0 : ((ov == OV_SEND) ? tx_free : 1'b1);
    assign ov_fire    = ovr_valid && ovr_ready;
    assign take_ovr   = ov_fire && (ov == OV_SEND) && !(variant_new && ovr_data == 8'h00);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ov      <= OV_IDLE;
            pfx_idx <= '0;
            ov_cnt  <= '0;
        end else begin
            unique case (ov)
                OV_IDLE: begin
                    if (ov_fire && ovr_first && !ovr_last) begin
                        ov      <= (ovr_data == prefix_char(4'h0)) ? OV_PREFIX : OV_IDLE;
                        pfx_idx <= 4'h1;
                    end
                end
                OV_PREFIX: begin
                    if (ov_fire) begin
                        pfx_idx <= pfx_idx + 4'h1;
                        ov_cnt  <= '0;
                        if (ovr_last || ovr_data != prefix_char(pfx_idx)) begin
                            ov <= ovr_last ? OV_IDLE : OV_DISCARD;
                        end else if (pfx_idx == 4'(`PREFIX_LEN - 1)) begin
                            ov <= OV_SEND; // RQ1
                        end
                    end
                end
                OV_SEND: begin // RQ4
                    if (ov_fire) begin
                        ov_cnt <= ov_cnt + 6'h01;
                        if (ovr_last) begin
                            ov <= OV_DRAIN;
                        end else if (variant_new && ovr_data == 8'h00) begin
                            ov <= OV_DISCARD; // RQ5
                        end else if (!variant_new && ov_cnt == 6'(`LEGACY_MAX - 1)) begin
                            ov <= OV_DISCARD; // RQ2
                        end
                    end
                end
                OV_DISCARD: begin
                    if (ov_fire && ovr_last) begin
                        ov <= OV_DRAIN;
                    end
                end
                OV_DRAIN: begin
                    if (tx_st == TX_IDLE) begin
                        ov <= OV_IDLE; // RQ7
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Host to target frame intake
    // ************************************************************
    logic [2:0] tx_frames;
    logic       in_frame;
    logic       h2t_fire;
    logic       tx_frame_done;

    // Session traffic waits while an override runs
    assign h2t_ready = dtr && !ovr_active && txq.wr_ready
                       && (in_frame || tx_frames < 3'(`TX_FRAMES)); // RQ10 RQ24 RQ7
    assign h2t_fire  = h2t_valid && h2t_ready;
    assign txq.wr_data  = {h2t_last, h2t_data};
    assign txq.wr_valid = h2t_fire;
    assign txq.commit   = 1'b1;
    assign txq.rewind   = 1'b0;
    assign txq.rd_ready = take_fifo;
    assign tx_frame_done = take_fifo && txq.rd_data[8];

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_frames <= '0;
            in_frame  <= 1'b0;
        end else begin
            if (h2t_fire) begin
                in_frame <= !h2t_last; // RQ9
            end
            tx_frames <= tx_frames + 3'(h2t_fire && !in_frame) - 3'(tx_frame_done);
        end
    end

    // ************************************************************
    // Transmitter and break
    // ************************************************************
    logic [11:0] tx_sh;
    logic [3:0]  tx_bits;
    div_t        tx_baud;
    logic [7:0]  tx_byte;
    logic        par_en;
    logic        par_bit;
    logic [33:0] brk_cnt;
    logic [33:0] brk_target;
    logic [33:0] brk_min;
    logic [33:0] brk_req_cyc;

    assign tx_free   = (tx_st == TX_IDLE) && !brk_go;
    assign take_fifo = tx_free && !ovr_active && txq.rd_valid; // RQ25
    assign tx_byte   = take_ovr ? ovr_data : txq.rd_data[7:0];
    assign par_en    = parity != PAR_NONE;
    assign par_bit   = (parity == PAR_ODD) ? ~^tx_byte : ^tx_byte; // RQ23
    assign brk_go    = (brk_hold || brk_timed) && (tx_st != TX_BREAK);
    assign brk_min   = 34'(`BRK_BITS) * 34'(sess_div);
    assign brk_req_cyc = 34'(brk_ms) * 34'(`CYC_PER_MS);
    assign brk_active = tx_st == TX_BREAK;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_st          <= TX_IDLE;
            bridge_tx_line <= 1'b1;
            tx_sh          <= '1;
            tx_bits        <= '0;
            tx_baud        <= '0;
            cur_div        <= DIV_OVR;
            brk_cnt        <= '0;
            brk_target     <= '0;
        end else if (brk_go) begin
            // Any character in flight is dropped here
            tx_st          <= TX_BREAK; // RQ17
            bridge_tx_line <= 1'b0;
            brk_cnt        <= 34'h1;
            if (brk_timed && brk_req_cyc > brk_min) begin
                brk_target <= (brk_req_cyc > BRK_CAP_CYC) ? BRK_CAP_CYC : brk_req_cyc; // RQ20
            end else begin
                brk_target <= brk_min; // RQ16
            end
        end else begin
            unique case (tx_st)
                TX_IDLE: begin
                    if (take_ovr || take_fifo) begin
                        tx_st   <= TX_SHIFT;
                        tx_sh   <= par_en ? {2'b11, par_bit, tx_byte, 1'b0}
                                          : {3'b111, tx_byte, 1'b0}; // RQ25
                        tx_bits <= 4'hA + 4'(par_en) + 4'(two_stop);
                        tx_baud <= '0;
                        cur_div <= (take_ovr && !ovr_keep) ? DIV_OVR : sess_div; // RQ6 RQ3
                        bridge_tx_line <= 1'b0;
                    end
                end
                TX_SHIFT: begin
                    if (tx_baud == cur_div - div_t'(1)) begin
                        tx_baud <= '0;
                        if (tx_bits == 4'h1) begin
                            tx_st          <= TX_IDLE;
                            bridge_tx_line <= 1'b1;
                        end else begin
                            tx_bits        <= tx_bits - 4'h1;
                            tx_sh          <= {1'b1, tx_sh[11:1]};
                            bridge_tx_line <= tx_sh[1];
                        end
                    end else begin
                        tx_baud <= tx_baud + div_t'(1);
                    end
                end
                TX_BREAK: begin
                    brk_cnt <= brk_cnt + 34'h1;
                    if (brk_cnt >= brk_target && !brk_hold) begin
                        tx_st          <= TX_IDLE; // RQ21
                        bridge_tx_line <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Receiver
    // ************************************************************
    rx_state_e  rx_st;
    div_t       rx_baud;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic       rx_byte_v;
    logic       rx_en;

    assign rx_en = dtr && !ovr_active; // RQ24 RQ7

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_st     <= RX_IDLE;
            rx_baud   <= '0;
            rx_bit    <= '0;
            rx_sh     <= '0;
            rx_byte_v <= 1'b0;
        end else begin
            rx_byte_v <= 1'b0;
            unique case (rx_st)
                RX_IDLE: begin
                    rx_baud <= '0;
                    rx_bit  <= '0;
                    if (rx_en && !bridge_rx_line) begin
                        rx_st <= RX_START;
                    end
                end
                RX_START: begin
                    rx_baud <= rx_baud + div_t'(1);
                    if (rx_baud == (sess_div >> 1)) begin
                        rx_baud <= '0;
                        rx_st   <= bridge_rx_line ? RX_IDLE : RX_BITS;
                    end
                end
                RX_BITS: begin
                    rx_baud <= rx_baud + div_t'(1);
                    if (rx_baud == sess_div - div_t'(1)) begin
                        rx_baud <= '0;
                        rx_bit  <= rx_bit + 4'h1;
                        if (rx_bit < 4'h8) begin
                            rx_sh <= {bridge_rx_line, rx_sh[7:1]};
                        end else if (rx_bit == 4'h8 + 4'(par_en)) begin
                            // A low stop bit is a framing error; the byte is dropped
                            rx_byte_v <= bridge_rx_line && rx_en;
                            rx_st     <= RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Receive frame packing
    // ************************************************************
    logic [7:0] stg;
    logic       stg_v;
    logic [6:0] fcnt;
    logic       flush_pend;
    logic [6:0] sof_cnt;
    logic [3:0] in_flight;
    logic       close;
    logic       lost;
    logic       t2h_done;

    // Last byte is staged so its frame end flag is known when written
    assign close = stg_v && !rx_byte_v && (fcnt == 7'(`FRAME_BYTES) || flush_pend); // RQ11 RQ12
    assign rxq.wr_valid = (rx_byte_v && stg_v) || close;
    assign rxq.wr_data  = {close, stg};
    assign lost         = rxq.wr_valid && !rxq.wr_ready;
    assign rxq.commit   = close && rxq.wr_ready && in_flight != 4'(`RX_FRAMES); // RQ13
    assign rxq.rewind   = (close && in_flight == 4'(`RX_FRAMES)) || lost; // RQ14
    assign rxq.rd_ready = t2h_ready;
    assign t2h_valid    = rxq.rd_valid;
    assign t2h_data     = rxq.rd_data[7:0];
    assign t2h_last     = rxq.rd_data[8];
    assign t2h_done     = t2h_valid && t2h_ready && t2h_last;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stg   <= '0;
            stg_v <= 1'b0;
            fcnt  <= '0;
        end else if (rx_byte_v) begin
            stg   <= rx_sh;
            stg_v <= 1'b1;
            fcnt  <= lost ? 7'h01 : fcnt + 7'h01;
        end else if (close) begin
            stg_v <= 1'b0;
            fcnt  <= '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sof_cnt    <= '0;
            flush_pend <= 1'b0;
        end else begin
            if (sof) begin
                sof_cnt <= (sof_cnt == 7'(`FLUSH_SOFS - 1)) ? 7'h00 : sof_cnt + 7'h01;
            end
            if (sof && sof_cnt == 7'(`FLUSH_SOFS - 1)) begin
                flush_pend <= 1'b1; // RQ12
            end else if (close || !stg_v) begin
                flush_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            in_flight <= '0;
        end else begin
            in_flight <= in_flight + 4'(rxq.commit) - 4'(t2h_done);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [33:0] brk_len;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            brk_len <= '0;
        end else begin
            brk_len <= brk_active ? brk_len + 34'h1 : 34'h0;
        end
    end

    property p_tx_slots;
        @(posedge sys_clk) disable iff (rst)
        (h2t_ready && !in_frame) |-> tx_frames < 3'(`TX_FRAMES);
    endproperty
    a_tx_slots: assert property (p_tx_slots) else $error("frame slots exceeded"); // RQ10

    property p_rx_flight;
        @(posedge sys_clk) disable iff (rst)
        rxq.commit |=> in_flight <= 4'(`RX_FRAMES) && in_flight == $past(in_flight) + 4'h1
                       - 4'($past(t2h_done));
    endproperty
    a_rx_flight: assert property (p_rx_flight) else $error("receive frames miscounted"); // RQ13

    property p_overrun;
        @(posedge sys_clk) disable iff (rst)
        (close && in_flight == 4'(`RX_FRAMES)) |-> rxq.rewind && !rxq.commit;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun frame was queued"); // RQ14

    property p_brk_min;
        @(posedge sys_clk) disable iff (rst)
        $fell(brk_active) |-> $past(brk_len) >= 34'(`BRK_BITS) * 34'($past(sess_div)) - 34'h1;
    endproperty
    a_brk_min: assert property (p_brk_min) else $error("break too short"); // RQ16

    property p_brk_abort;
        @(posedge sys_clk) disable iff (rst)
        (tx_st == TX_SHIFT && brk_hold) |=> brk_active && !bridge_tx_line;
    endproperty
    a_brk_abort: assert property (p_brk_abort) else $error("break did not abort"); // RQ17

    property p_dtr;
        @(posedge sys_clk) disable iff (rst)
        !dtr |-> !h2t_ready ##1 !rx_byte_v;
    endproperty
    a_dtr: assert property (p_dtr) else $error("data moved without terminal ready"); // RQ24

    property p_suspend;
        @(posedge sys_clk) disable iff (rst)
        ovr_active |-> !take_fifo && !h2t_ready;
    endproperty
    a_suspend: assert property (p_suspend) else $error("session ran during override"); // RQ7

    property p_legacy_cap;
        @(posedge sys_clk) disable iff (rst)
        (ov == OV_SEND && !variant_new) |-> ov_cnt < 6'(`LEGACY_MAX);
    endproperty
    a_legacy_cap: assert property (p_legacy_cap) else $error("legacy override too long"); // RQ2

    property p_null_stop;
        @(posedge sys_clk) disable iff (rst)
        (ov == OV_SEND && ov_fire && variant_new && ovr_data == 8'h00)
        |-> !take_ovr ##1 (ov == OV_DISCARD || ov == OV_DRAIN);
    endproperty
    a_null_stop: assert property (p_null_stop) else $error("sent past null"); // RQ5

    property p_ovr_rate;
        @(posedge sys_clk) disable iff (rst)
        (take_ovr && variant_new) |=> cur_div == DIV_OVR;
    endproperty
    a_ovr_rate: assert property (p_ovr_rate) else $error("override rate wrong"); // RQ6
endmodule

// ==== tb/uart_target.sv ====
// Target side model: decodes the bridge output, drives the bridge input
`timescale 1ns/1ns
module uart_target #(parameter int DIV = 250) (
    input  wire logic sys_clk,
    input  wire logic tx,
    output logic      rx
);
    logic [7:0] got[$];
    logic [7:0] b;
    initial rx = 1'b1;
    // Mid-bit sampling; a low stop bit (break, abort) yields no byte
    always begin
        @(negedge tx);
        repeat (DIV + DIV / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            b[i] = tx;
            repeat (DIV) @(posedge sys_clk);
        end
        if (tx) got.push_back(b);
    end
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge sys_clk) rx = f[i];
            repeat (DIV - 1) @(negedge sys_clk);
        end
    endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the serial bridge core
`timescale 1ns/1ns
`include "bridge_consts.svh"
module testbench;
    import bridge_pkg::*;
    logic        sys_clk = 0, rst = 1, dtr = 0, sof = 0, t2h_ready = 0;
    logic        h2t_valid = 0, h2t_last = 0, brk_hold = 0, brk_timed = 0;
    logic        ovr_valid = 0, ovr_first = 0, ovr_last = 0;
    logic        variant_new = 1, line_cfg_valid = 1;
    logic [7:0]  h2t_data = 0, ovr_data = 0, t2h_data;
    logic [15:0] brk_ms = 0;
    logic        h2t_ready, t2h_valid, t2h_last, ovr_ready, ovr_active, brk_active, rx, tx;
    logic [31:0] seed = 32'h3064b5e7;
    logic [7:0]  exp_q[$];
    int          err_count = 0, checks_done = 0, cyc = 0, n;
    string       pfx = `PREFIX_TEXT;
    usb_uart_bridge #(.BRK_CAP_CYC(34'hFA0)) usb_uart_bridge_inst (.sys_clk(sys_clk),
        .rst(rst), .dtr(dtr), .variant_new(variant_new), .line_cfg_valid(line_cfg_valid),
        .baud_req(32'h0007A120), .parity(PAR_NONE), .two_stop(1'b0), .h2t_data(h2t_data),
        .h2t_valid(h2t_valid), .h2t_last(h2t_last), .h2t_ready(h2t_ready),
        .t2h_data(t2h_data), .t2h_valid(t2h_valid), .t2h_last(t2h_last),
        .t2h_ready(t2h_ready), .sof(sof), .ovr_data(ovr_data), .ovr_valid(ovr_valid),
        .ovr_first(ovr_first), .ovr_last(ovr_last), .ovr_ready(ovr_ready),
        .ovr_active(ovr_active), .brk_hold(brk_hold), .brk_timed(brk_timed),
        .brk_ms(brk_ms), .brk_active(brk_active), .bridge_rx_line(rx), .bridge_tx_line(tx));
    uart_target #(.DIV(250)) uart_target_inst (.sys_clk(sys_clk), .tx(tx), .rx(rx));
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        // Whole run needs about 63k cycles
        if (cyc == 90000) begin
            err_count++;
            results();
        end
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic host(input logic [7:0] d, input logic l);
        @(negedge sys_clk);
        {h2t_data, h2t_last, h2t_valid} = {d, l, 1'b1};
        while (h2t_ready !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk) h2t_valid = 0;
    endtask
    task automatic ovr(input logic [7:0] d, input logic f, input logic l);
        @(negedge sys_clk);
        {ovr_data, ovr_first, ovr_last, ovr_valid} = {d, f, l, 1'b1};
        while (ovr_ready !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk) ovr_valid = 0;
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge sys_clk);
        rst = 0;
        chk({tx, t2h_valid, brk_active, ovr_active, h2t_ready}, 5'h10);
        dtr = 1;
        for (int i = 0; i < 8; i++) begin
            exp_q.push_back(rnd());
            host(exp_q[i], i[1:0] == 2'h3);
        end
        repeat (22000) @(negedge sys_clk);
        chk(uart_target_inst.got.size(), 8);
        foreach (exp_q[i]) chk(uart_target_inst.got[i], exp_q[i]);
        exp_q = {8'h00, 8'hFF, rnd()};
        foreach (exp_q[i]) uart_target_inst.send(exp_q[i]);
        repeat (100) begin
            @(negedge sys_clk) sof = 1;
            @(negedge sys_clk) sof = 0;
        end
        t2h_ready = 1;
        for (n = 0; n < 3; n++) begin
            while (t2h_valid !== 1'b1) @(negedge sys_clk);
            chk({t2h_data, t2h_last}, {exp_q[n], n == 2});
            @(negedge sys_clk);
        end
        uart_target_inst.got.delete();
        host(rnd(), 1'b1);
        repeat (600) @(negedge sys_clk);
        brk_hold = 1;
        @(negedge sys_clk) brk_hold = 0;
        for (n = 0; brk_active === 1'b1 && n < 9000; n++) @(negedge sys_clk);
        chk(n >= 11 * 250 - 2, 1);
        brk_ms = 16'h0001;
        brk_timed = 1;
        @(negedge sys_clk) brk_timed = 0;
        for (n = 0; brk_active === 1'b1 && n < 9000; n++) @(negedge sys_clk);
        chk(n, 4000);
        repeat (3000) @(negedge sys_clk);
        chk(uart_target_inst.got.size(), 0);
        for (int i = 0; i < `PREFIX_LEN; i++) ovr(pfx[i], i == 0, 1'b0);
        chk({ovr_active, h2t_ready}, 2'h2);
        ovr(8'h00, 1'b0, 1'b0);
        ovr(8'h41, 1'b0, 1'b1);
        for (n = 0; ovr_active === 1'b1 && n < 200; n++) @(negedge sys_clk);
        repeat (20000) @(negedge sys_clk);
        chk({ovr_active, h2t_ready, uart_target_inst.got.size()}, 34'h100000000);
        variant_new = 0;
        for (int i = 0; i < `PREFIX_LEN; i++) ovr(pfx[i], i == 0, 1'b0);
        ovr(8'h5A, 1'b0, 1'b1);
        repeat (3000) @(negedge sys_clk);
        chk(uart_target_inst.got.size(), 1);
        chk(uart_target_inst.got[0], 8'h5A);
        results();
    end
endmodule
